// ==== core/ltc_pkg.sv ====
// package: register map, field positions, reset values and codes for line termination control
package ltc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TERM_CTRL_OFFSET   = 8'h01;
    localparam logic [7:0] IMPEDANCE_OFFSET   = 8'h02;
    localparam logic [7:0] RATIO_CTRL_OFFSET  = 8'h03;
    localparam logic [7:0] PIN_HANDOVER_OFFSET = 8'h12;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RX_TERM_BIT      = 7;
    localparam int TX_TERM_BIT      = 6;
    localparam int TURNS_RATIO_BIT  = 0;
    localparam int IMPEDANCE_LO_BIT = 0;
    localparam int IMPEDANCE_HI_BIT = 1;
    localparam int TX_ON_BIT        = 2;
    localparam int TX_ONOFF_HO_BIT  = 5;
    localparam int RX_TERM_HO_BIT   = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TERM_CTRL_RESET    = 8'h00;
    localparam logic [7:0] IMPEDANCE_RESET    = 8'h00;
    localparam logic [7:0] RATIO_CTRL_RESET   = 8'h00;
    localparam logic [7:0] PIN_HANDOVER_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE_VALUE    = 8'h00;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    // impedance select
    localparam logic [1:0] IMP_100_OHM = 2'h0;
    localparam logic [1:0] IMP_110_OHM = 2'h1;
    localparam logic [1:0] IMP_75_OHM  = 2'h2;
    localparam logic [1:0] IMP_120_OHM = 2'h3;
    // internal transmit resistance in quarter-ohm steps
    localparam logic [7:0] RINT_OFF      = 8'h00;
    localparam logic [7:0] RINT_25_OHM   = 8'h64;
    localparam logic [7:0] RINT_27P5_OHM = 8'h6E;
    localparam logic [7:0] RINT_18P75_OHM = 8'h4B;
    localparam logic [7:0] RINT_30_OHM   = 8'h78;
    // turns ratio: 0 is 1:2, 1 is 1:2.45
    localparam logic RATIO_1_TO_2    = 1'b0;
    localparam logic RATIO_1_TO_2P45 = 1'b1;
    localparam int   PIN_COUNT       = 7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       host_mode;
        logic       tx_term_internal_sel;
        logic       rx_term_internal_sel;
        logic       turns_ratio_sel;
        logic       impedance_sel_hi;
        logic       impedance_sel_lo;
        logic       tx_output_on_pin;
    } ltc_pins_s;

    typedef struct packed {
        logic       tx_term_internal;
        logic       rx_term_internal;
        logic       turns_ratio;
        logic [1:0] impedance;
        logic [7:0] tx_rint;
        logic       tx_output_on;
    } ltc_term_s;

endpackage

// ==== core/ltc_pin_sync.sv ====
// two-flop synchroniser bank for the hardware strap and control pins
`timescale 1ns/1ps
module ltc_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_in,
    input  wire logic         srst_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // ------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // first stage feeds only the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (ce_in) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// ==== core/ltc_line_term_ctrl.sv ====
// line termination control: host registers, strap pins and termination decode
`timescale 1ns/1ps
module ltc_line_term_ctrl (
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic              ce_in,
    // host register port
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    output logic      [7:0]        reg_rdata_out,
    output logic                   reg_rvalid_out,
    // hardware pins, asynchronous
    input  wire ltc_pkg::ltc_pins_s pins_in,
    // resolved termination
    output ltc_pkg::ltc_term_s     term_out
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    ltc_pkg::ltc_pins_s pins_sync;

    // every strap crosses two flops so a pin moved near an edge never reaches decode while metastable
    ltc_pin_sync #(
        .W (ltc_pkg::PIN_COUNT)
    ) u_pin_sync (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .ce_in       (ce_in),
        .async_in    (pins_in),
        .sync_out    (pins_sync)
    );

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // internal transmit resistance, quarter-ohm steps
    function automatic logic [7:0] rint_decode(input logic internal_sel,
                                               input logic [1:0] imp);
        logic [7:0] r;
        r = ltc_pkg::RINT_OFF;
        if (internal_sel) begin
            unique case (imp)
                ltc_pkg::IMP_100_OHM: r = ltc_pkg::RINT_25_OHM;
                ltc_pkg::IMP_110_OHM: r = ltc_pkg::RINT_27P5_OHM;
                ltc_pkg::IMP_75_OHM:  r = ltc_pkg::RINT_18P75_OHM;
                ltc_pkg::IMP_120_OHM: r = ltc_pkg::RINT_30_OHM;
            endcase
        end
        return r; // external leaves zero
    endfunction

    // full 8-bit compare: partial decode would alias unmapped writes onto 0x12
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] offset);
        return addr == offset;
    endfunction

    // ------------------------------------------------------------
    // host registers
    // ------------------------------------------------------------
    logic [7:0] term_ctrl_q;
    logic [7:0] term_ctrl_d;
    logic [7:0] impedance_q;
    logic [7:0] impedance_d;
    logic [7:0] ratio_ctrl_q;
    logic [7:0] ratio_ctrl_d;
    logic [7:0] handover_q;
    logic [7:0] handover_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;

    // ce low is applied in the flop stage, so a strobe while frozen is simply lost
    always_comb begin
        term_ctrl_d  = term_ctrl_q;
        impedance_d  = impedance_q;
        ratio_ctrl_d = ratio_ctrl_q;
        handover_d   = handover_q;
        if (reg_wr_in) begin
            if (addr_hit(reg_addr_in, ltc_pkg::TERM_CTRL_OFFSET)) begin
                term_ctrl_d = reg_wdata_in;
            end
            if (addr_hit(reg_addr_in, ltc_pkg::IMPEDANCE_OFFSET)) begin
                impedance_d = reg_wdata_in;
            end
            if (addr_hit(reg_addr_in, ltc_pkg::RATIO_CTRL_OFFSET)) begin
                ratio_ctrl_d = reg_wdata_in;
            end
            if (addr_hit(reg_addr_in, ltc_pkg::PIN_HANDOVER_OFFSET)) begin
                handover_d = reg_wdata_in;
            end
        end
    end

    // reads return stored values; unmapped addresses read zero
    always_comb begin
        rvalid_d = reg_rd_in;
        rdata_d  = ltc_pkg::READ_IDLE_VALUE;
        if (reg_rd_in) begin
            if (addr_hit(reg_addr_in, ltc_pkg::TERM_CTRL_OFFSET)) begin
                rdata_d = term_ctrl_q;
            end else if (addr_hit(reg_addr_in, ltc_pkg::IMPEDANCE_OFFSET)) begin
                rdata_d = impedance_q;
            end else if (addr_hit(reg_addr_in, ltc_pkg::RATIO_CTRL_OFFSET)) begin
                rdata_d = ratio_ctrl_q;
            end else if (addr_hit(reg_addr_in, ltc_pkg::PIN_HANDOVER_OFFSET)) begin
                rdata_d = handover_q;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            term_ctrl_q  <= ltc_pkg::TERM_CTRL_RESET;
            impedance_q  <= ltc_pkg::IMPEDANCE_RESET;
            ratio_ctrl_q <= ltc_pkg::RATIO_CTRL_RESET;
            handover_q   <= ltc_pkg::PIN_HANDOVER_RESET;
            rdata_q      <= ltc_pkg::READ_IDLE_VALUE;
            rvalid_q     <= 1'b0;
        end else if (ce_in) begin
            term_ctrl_q  <= term_ctrl_d;
            impedance_q  <= impedance_d;
            ratio_ctrl_q <= ratio_ctrl_d;
            handover_q   <= handover_d;
            rdata_q      <= rdata_d;
            rvalid_q     <= rvalid_d;
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    logic       sel_tx_internal;
    logic       sel_rx_internal;
    logic       sel_ratio;
    logic [1:0] sel_imp;
    logic       sel_tx_on;

    // host_mode is live, not latched: a strap change reroutes every source not handed over to its pin
    // three edges later, which keeps board rework simple at the cost of a glitch window
    always_comb begin
        if (pins_sync.host_mode) begin
            sel_tx_internal = term_ctrl_q[ltc_pkg::TX_TERM_BIT];
            sel_ratio       = ratio_ctrl_q[ltc_pkg::TURNS_RATIO_BIT];
            sel_imp         = {impedance_q[ltc_pkg::IMPEDANCE_HI_BIT],
                               impedance_q[ltc_pkg::IMPEDANCE_LO_BIT]};
            // pin takes over only while its handover bit is set
            if (handover_q[ltc_pkg::RX_TERM_HO_BIT]) begin
                sel_rx_internal = pins_sync.rx_term_internal_sel;
            end else begin
                sel_rx_internal = term_ctrl_q[ltc_pkg::RX_TERM_BIT];
            end
            if (handover_q[ltc_pkg::TX_ONOFF_HO_BIT]) begin
                sel_tx_on = pins_sync.tx_output_on_pin;
            end else begin
                sel_tx_on = impedance_q[ltc_pkg::TX_ON_BIT];
            end
        end else begin
            sel_tx_internal = pins_sync.tx_term_internal_sel;
            sel_rx_internal = pins_sync.rx_term_internal_sel;
            sel_ratio       = pins_sync.turns_ratio_sel;
            sel_imp         = {pins_sync.impedance_sel_hi, pins_sync.impedance_sel_lo};
            sel_tx_on       = pins_sync.tx_output_on_pin;
        end
    end

    // ------------------------------------------------------------
    // termination decode
    // ------------------------------------------------------------
    // outputs registered so the analog controls never see decode glitches
    ltc_pkg::ltc_term_s term_q;
    ltc_pkg::ltc_term_s term_d;

    always_comb begin
        term_d.tx_term_internal = sel_tx_internal;
        term_d.rx_term_internal = sel_rx_internal;
        term_d.impedance        = sel_imp;
        term_d.tx_rint          = rint_decode(sel_tx_internal, sel_imp);
        term_d.tx_output_on     = sel_tx_on;
        // internal mode always runs 1:2, the select is ignored
        if (sel_tx_internal) begin
            term_d.turns_ratio = ltc_pkg::RATIO_1_TO_2;
        end else begin
            term_d.turns_ratio = sel_ratio ? ltc_pkg::RATIO_1_TO_2P45
                                           : ltc_pkg::RATIO_1_TO_2;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            term_q.tx_term_internal <= 1'b0;
            term_q.rx_term_internal <= 1'b0;
            term_q.turns_ratio      <= ltc_pkg::RATIO_1_TO_2;
            term_q.impedance        <= ltc_pkg::IMP_100_OHM;
            term_q.tx_rint          <= ltc_pkg::RINT_OFF;
            term_q.tx_output_on     <= 1'b0;
        end else if (ce_in) begin
            term_q <= term_d;
        end
    end

    assign term_out = term_q;

endmodule

// ==== dv/ltc_strap_model.sv ====
// strap pin model: board straps and control pins that move between settled levels
`timescale 1ns/1ps
module ltc_strap_model (
    input  wire logic               core_clk_in,
    input  wire ltc_pkg::ltc_pins_s want_in,
    output ltc_pkg::ltc_pins_s      pins_out
);
    // levels move just after an edge, never racing the design's sampling edge
    initial pins_out = '0;
    always @(posedge core_clk_in) pins_out <= #1 want_in;
endmodule

// ==== dv/ltc_line_term_ctrl_props.sv ====
// checker: port-level assertions for line termination control
`timescale 1ns/1ps
module ltc_line_term_ctrl_props (
    input wire logic               core_clk_in,
    input wire logic               srst_in,
    input wire logic               ce_in,
    input wire logic               reg_wr_in,
    input wire logic               reg_rd_in,
    input wire logic [7:0]         reg_addr_in,
    input wire logic [7:0]         reg_wdata_in,
    input wire logic [7:0]         reg_rdata_out,
    input wire logic               reg_rvalid_out,
    input wire ltc_pkg::ltc_pins_s pins_in,
    input wire ltc_pkg::ltc_term_s term_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);
    function automatic logic [7:0] rint_f(input logic [1:0] i);
        return i == 2'h0 ? ltc_pkg::RINT_25_OHM : i == 2'h1 ? ltc_pkg::RINT_27P5_OHM :
               i == 2'h2 ? ltc_pkg::RINT_18P75_OHM : ltc_pkg::RINT_30_OHM;
    endfunction
    // hardware mode needs the sync pipe full of hardware-mode samples
    sequence s_hw;
        (ce_in && !pins_in.host_mode) [*4];
    endsequence
    property p_rvalid; ce_in && reg_rd_in |=> reg_rvalid_out; endproperty
    property p_idle; !reg_rvalid_out |-> reg_rdata_out == ltc_pkg::READ_IDLE_VALUE; endproperty
    property p_reset; $fell(srst_in) |-> term_out == '0 && !reg_rvalid_out; endproperty
    property p_rint_ext;
        !term_out.tx_term_internal |-> term_out.tx_rint == ltc_pkg::RINT_OFF;
    endproperty
    property p_rint_int;
        term_out.tx_term_internal |-> term_out.tx_rint == rint_f(term_out.impedance);
    endproperty
    property p_ratio_int;
        term_out.tx_term_internal |-> term_out.turns_ratio == ltc_pkg::RATIO_1_TO_2;
    endproperty
    property p_hw_tx;
        s_hw |-> term_out.tx_term_internal == $past(pins_in.tx_term_internal_sel, 3);
    endproperty
    property p_hw_ratio;
        s_hw ##0 !term_out.tx_term_internal |->
            term_out.turns_ratio == $past(pins_in.turns_ratio_sel, 3);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");
    a_idle: assert property (p_idle) else $error("read data not idle");
    a_reset: assert property (p_reset) else $error("reset outputs wrong");
    a_rint_ext: assert property (p_rint_ext) else $error("external rint not zero");
    a_rint_int: assert property (p_rint_int) else $error("internal rint wrong");
    a_ratio_int: assert property (p_ratio_int) else $error("ratio not ignored");
    a_hw_tx: assert property (p_hw_tx) else $error("tx select not from pin");
    a_hw_ratio: assert property (p_hw_ratio) else $error("ratio not from pin");
    c_write: cover property (ce_in && reg_wr_in && pins_in.host_mode);
    c_internal: cover property (term_out.tx_term_internal);
    c_read: cover property (reg_rvalid_out && reg_rdata_out != 8'h00);
endmodule
bind ltc_line_term_ctrl ltc_line_term_ctrl_props u_props (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .ce_in(ce_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .pins_in(pins_in), .term_out(term_out));

// ==== dv/ltc_line_term_ctrl_tb.sv ====
// testbench: scoreboard of registers and straps for line termination control
`timescale 1ns/1ps
module ltc_line_term_ctrl_tb;
    logic               core_clk_in, srst_in, ce_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
    logic [7:0]         reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [15:0]        t0;
    ltc_pkg::ltc_pins_s want, pins_in;
    ltc_pkg::ltc_term_s term_out;
    int                 mismatches, tests_run, cycles;
    int                 regs[int];
    int                 ohm[4] = '{100, 110, 75, 120};
    logic [7:0]         offs[4] = '{ltc_pkg::TERM_CTRL_OFFSET, ltc_pkg::IMPEDANCE_OFFSET,
                                    ltc_pkg::RATIO_CTRL_OFFSET, ltc_pkg::PIN_HANDOVER_OFFSET};
    ltc_line_term_ctrl uut (.core_clk_in(core_clk_in), .srst_in(srst_in), .ce_in(ce_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .pins_in(pins_in), .term_out(term_out));
    ltc_strap_model u_strap (.core_clk_in(core_clk_in), .want_in(want), .pins_out(pins_in));
    initial begin
        core_clk_in = 1'h0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    task automatic end_sim();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // a hang is cut short well beyond the roughly 630 cycles the run needs
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr_in = 1'h1;
        reg_addr_in = a;
        reg_wdata_in = d;
        step(1);
        reg_wr_in = 1'h0;
        if (ce_in && regs.exists(a)) regs[a] = d;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_rd_in = 1'h1;
        reg_addr_in = a;
        step(1);
        reg_rd_in = 1'h0;
        chk("rvalid", 16'(reg_rvalid_out), 16'h0001);
        chk("rdata", 16'(reg_rdata_out), regs.exists(a) ? 16'(regs[a]) : 16'h0000);
        step(1);
        chk("rvalid end", 16'(reg_rvalid_out), 16'h0000);
    endtask
    function automatic logic [15:0] exp_term();
        ltc_pkg::ltc_term_s t;
        logic [7:0]         c, i, r, h;
        logic               hm;
        hm = want.host_mode;
        c = 8'(regs[1]);
        i = 8'(regs[2]);
        r = 8'(regs[3]);
        h = 8'(regs[18]);
        t.tx_term_internal = hm ? c[6] : want.tx_term_internal_sel;
        t.rx_term_internal = (hm && !h[4]) ? c[7] : want.rx_term_internal_sel;
        t.impedance = hm ? i[1:0] : {want.impedance_sel_hi, want.impedance_sel_lo};
        t.turns_ratio = !t.tx_term_internal && (hm ? r[0] : want.turns_ratio_sel);
        t.tx_rint = t.tx_term_internal ? 8'(ohm[t.impedance]) : 8'h00;
        t.tx_output_on = (hm && !h[5]) ? i[2] : want.tx_output_on_pin;
        return 16'(t);
    endfunction
    initial begin
        {srst_in, ce_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 20'hC0000;
        want = '0;
        regs = '{1:0, 2:0, 3:0, 18:0};
        void'($urandom(19100));
        step(20);
        srst_in = 1'h0;
        step(1);
        chk("term reset", 16'(term_out), 16'h0000);
        foreach (regs[a]) rd(8'(a));
        $display("test reset done");
        for (int k = 0; k < 16; k++) begin
            want = ltc_pkg::ltc_pins_s'(7'($urandom));
            want.host_mode = 1'h0;
            {want.tx_term_internal_sel, want.turns_ratio_sel} = 2'(k >> 2);
            {want.impedance_sel_hi, want.impedance_sel_lo} = 2'(k);
            step(4);
            chk("term hw", 16'(term_out), exp_term());
        end
        $display("test hardware mode done");
        for (int k = 0; k < 64; k++) begin
            wr(offs[k % 4], 8'($urandom));
            want = ltc_pkg::ltc_pins_s'(7'($urandom));
            want.host_mode = 1'h1;
            step(4);
            chk("term host", 16'(term_out), exp_term());
            rd(offs[k % 4]);
        end
        $display("test host mode done");
        wr(8'h05, 8'hA5);
        rd(8'h05);
        t0 = 16'(term_out);
        ce_in = 1'h0;
        wr(ltc_pkg::TERM_CTRL_OFFSET, 8'hFF);
        want = ~want;
        step(4);
        chk("term frozen", 16'(term_out), t0);
        ce_in = 1'h1;
        step(4);
        chk("term thawed", 16'(term_out), exp_term());
        $display("test unmapped and freeze done");
        srst_in = 1'h1;
        step(3);
        srst_in = 1'h0;
        foreach (regs[a]) regs[a] = 0;
        step(1);
        chk("term rereset", 16'(term_out), 16'h0000);
        step(4);
        chk("term after reset", 16'(term_out), exp_term());
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
